// ==== design/ctq_pkg.sv ====
/*
  constants for the charge termination and temperature qualifier.
  assumes a single 125 MHz clock; no register bus, all bits are ports.
*/
package ctq_pkg;
  // ==========================================================
  // clock and timing
  localparam int CLK_MHZ = 125;
  localparam int TERM_QUAL_CYC = 8;       // consecutive cycles of termination
  localparam int IRQ_PULSE_US = 256;      // interrupt pulse width
  localparam int IRQ_PULSE_CYC = IRQ_PULSE_US * CLK_MHZ;
  localparam int SEC_CYC = CLK_MHZ * 1000000;
  localparam int TOPOFF_STEP_SEC = 900;   // seconds per top-off setting step
  // ==========================================================
  // temperature zone codes
  localparam logic [2:0] ZONE_NOMINAL = 3'h0;
  localparam logic [2:0] ZONE_PRECOOL = 3'h1;
  localparam logic [2:0] ZONE_COOL = 3'h2;
  localparam logic [2:0] ZONE_COLD = 3'h3;
  localparam logic [2:0] ZONE_PREWARM = 3'h4;
  localparam logic [2:0] ZONE_WARM = 3'h5;
  localparam logic [2:0] ZONE_HOT = 3'h6;
  // ==========================================================
  // charge phase codes
  localparam logic [1:0] PHASE_IDLE = 2'h0;
  localparam logic [1:0] PHASE_CC = 2'h1;
  localparam logic [1:0] PHASE_CV = 2'h2;
  localparam logic [1:0] PHASE_TOPOFF = 2'h3;
  // ==========================================================
  // fold-back codes and results, in tenths of a percent
  localparam logic [1:0] FOLD_SUSPEND = 2'h0;
  localparam logic [1:0] FOLD_LOW = 2'h1;
  localparam logic [1:0] FOLD_HIGH = 2'h2;
  localparam logic [1:0] FOLD_FULL = 2'h3;
  localparam logic [9:0] PCT_FULL = 10'h3e8;  // 100.0
  localparam logic [9:0] PCT_ZERO = 10'h000;
  localparam logic [9:0] PCT_40 = 10'h190;
  localparam logic [9:0] PCT_20 = 10'h0c8;
  localparam logic [9:0] PCT_10 = 10'h064;
  localparam logic [9:0] PCT_6P6 = 10'h042;
  localparam logic [9:0] PCT_5 = 10'h032;
  localparam logic [9:0] PCT_3P3 = 10'h021;
  // ==========================================================
  // reset values
  localparam logic CONV_OFF_RST = 1'b0;
  localparam logic [6:0] ZONE_FLAGS_RST = 7'h00;
endpackage

// ==== design/ctq_core.sv ====
/*
  charge termination, top-off timer and thermistor zone qualification.
  assumes comparator and loop inputs are synchronous to clk; flag_read
  is a one-cycle pulse from the register side when flags are read.
*/
`timescale 1ns/1ps
module ctq_core
  import ctq_pkg::*;
#(
  parameter int IRQ_CYC = IRQ_PULSE_CYC,
  parameter int TICK_CYC = SEC_CYC
) (
  // clock and reset
  input wire logic clk,
  input wire logic rst,
  // charger status from the analog side
  input wire logic vbat_above_recharge,
  input wire logic cv_regulation,
  input wire logic below_term_current,
  input wire logic input_current_limit_loop,
  input wire logic input_voltage_limit_loop,
  input wire logic thermal_reg_loop,
  input wire logic supplement_req,
  input wire logic ext_timer_pause,
  input wire logic ext_half_rate,
  // charge configuration
  input wire logic charging_allow_bit,
  input wire logic term_enable,
  input wire logic reg_defaults_restore,
  input wire logic [1:0] topoff_setting,
  // thermistor configuration and zone input
  input wire logic [2:0] zone_raw,
  input wire logic thermistor_bypass,
  input wire logic conv_off_wr,
  input wire logic conv_off_wdata,
  input wire logic temp_zone_irq_mask,
  input wire logic [1:0] foldback_precool_zone,
  input wire logic [1:0] foldback_cool_zone,
  input wire logic [1:0] foldback_prewarm_zone,
  input wire logic [1:0] foldback_warm_zone,
  input wire logic [1:0] battery_c_rate_select,
  input wire logic flag_read,
  // charge status
  output logic term_status_ff,
  output logic battery_switch_on_ff,
  output logic [1:0] charge_phase_code_ff,
  output logic charge_phase_flag_ff,
  output logic topoff_run_ff,
  // temperature status
  output logic [2:0] temp_zone_code_ff,
  output logic [6:0] zone_flags_ff,
  output logic thermistor_conversion_off_ff,
  output logic irq_n,
  output logic [9:0] foldback_pct_ff,
  output logic safety_half_rate,
  output logic safety_pause,
  output logic stat_blink
);

  // ==========================================================
  // fold-back table
  // result in tenths of a percent so 3.3 and 6.6 stay exact
  function automatic logic [9:0] fold_pct(input logic [1:0] fb, input logic [1:0] cr);
    logic [9:0] r;
    r = PCT_FULL;
    if (fb == FOLD_SUSPEND) begin
      r = PCT_ZERO;
    end else if (fb == FOLD_LOW) begin
      r = (cr == 2'h0) ? PCT_20 : (cr == 2'h1) ? PCT_10 : (cr == 2'h2) ? PCT_5 : PCT_3P3;
    end else if (fb == FOLD_HIGH) begin
      r = (cr == 2'h0) ? PCT_40 : (cr == 2'h1) ? PCT_20 : (cr == 2'h2) ? PCT_10 : PCT_6P6;
    end
    return r;
  endfunction

  // ==========================================================
  // temperature zone selection
  logic [2:0] eff_zone;
  logic [1:0] zone_fold;
  logic [9:0] nxt_pct;
  logic temp_suspend;
  logic zone_change;
  // bypass reads as nominal, which is always valid for charging
  assign eff_zone = thermistor_bypass ? ZONE_NOMINAL : zone_raw;
  // precool, cool, prewarm and warm pick their own setting; nominal is full, cold and hot always suspend
  assign zone_fold = (eff_zone == ZONE_PRECOOL) ? foldback_precool_zone :
                     (eff_zone == ZONE_COOL) ? foldback_cool_zone :
                     (eff_zone == ZONE_PREWARM) ? foldback_prewarm_zone :
                     (eff_zone == ZONE_WARM) ? foldback_warm_zone :
                     (eff_zone == ZONE_NOMINAL) ? FOLD_FULL : FOLD_SUSPEND;
  assign nxt_pct = fold_pct(zone_fold, battery_c_rate_select);
  assign temp_suspend = (zone_fold == FOLD_SUSPEND);
  assign zone_change = (eff_zone != temp_zone_code_ff);
  // half rate only for the reduced cool and warm zones
  assign safety_half_rate = ((eff_zone == ZONE_COOL) || (eff_zone == ZONE_WARM)) &&
                            ((zone_fold == FOLD_LOW) || (zone_fold == FOLD_HIGH));
  assign safety_pause = temp_suspend || ext_timer_pause;

  // zone code and current fold-back
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_zone_code_ff <= ZONE_NOMINAL;
      foldback_pct_ff <= PCT_FULL;
    end else begin
      temp_zone_code_ff <= eff_zone;
      foldback_pct_ff <= nxt_pct;
    end
  end

  // zone flags: set of the new zone wins over a read in the same cycle
  logic [6:0] zone_set;
  genvar gz;
  generate
    for (gz = 0; gz < 7; gz++) begin : g_zflag
      assign zone_set[gz] = zone_change && (eff_zone == 3'(gz));
      always_ff @(posedge clk) begin
        if (rst) begin
          zone_flags_ff[gz] <= ZONE_FLAGS_RST[gz];
        end else if (zone_set[gz]) begin
          zone_flags_ff[gz] <= 1'b1;
        end else if (flag_read) begin
          zone_flags_ff[gz] <= 1'b0;
        end
      end
    end
  endgenerate

  // ==========================================================
  // interrupt pulse, stretched; a fresh change restarts it
  logic [15:0] irq_cnt_ff;
  logic [15:0] nxt_irq_cnt;
  assign nxt_irq_cnt = (zone_change && !temp_zone_irq_mask) ? 16'(IRQ_CYC) :
                       (irq_cnt_ff != 16'h0000) ? irq_cnt_ff - 16'h0001 : 16'h0000;
  assign irq_n = (irq_cnt_ff == 16'h0000);
  always_ff @(posedge clk) begin
    if (rst) irq_cnt_ff <= 16'h0000;
    else irq_cnt_ff <= nxt_irq_cnt;
  end

  // conversion-off bit held high under bypass
  always_ff @(posedge clk) begin
    if (rst) begin
      thermistor_conversion_off_ff <= CONV_OFF_RST;
    end else if (thermistor_bypass) begin
      thermistor_conversion_off_ff <= 1'b1;
    end else if (conv_off_wr) begin
      thermistor_conversion_off_ff <= conv_off_wdata;
    end
  end

  // ==========================================================
  // termination qualification
  logic term_cond;
  logic term_block_ff;
  logic [3:0] qual_cnt_ff;
  logic allow_q_ff;
  logic restart;
  logic term_hit;
  assign term_cond = charging_allow_bit && !temp_suspend && !term_block_ff &&
                     vbat_above_recharge && cv_regulation && below_term_current &&
                     !input_current_limit_loop && !input_voltage_limit_loop &&
                     !thermal_reg_loop && term_enable;
  // stop of charging or a recharge drop starts a fresh cycle
  assign restart = (allow_q_ff && !charging_allow_bit) ||
                   (term_status_ff && !vbat_above_recharge);
  // count saturates at TERM_QUAL_CYC - 1, glitches restart it
  assign term_hit = (qual_cnt_ff == 4'(TERM_QUAL_CYC - 1)) && term_cond;

  always_ff @(posedge clk) begin
    if (rst) begin
      qual_cnt_ff <= 4'h0;
      allow_q_ff <= 1'b0;
    end else begin
      qual_cnt_ff <= (!term_cond || term_status_ff) ? 4'h0 :
                     term_hit ? qual_cnt_ff : qual_cnt_ff + 4'h1;
      allow_q_ff <= charging_allow_bit;
    end
  end

  // disable sticks until defaults restore; a late clear has no effect
  always_ff @(posedge clk) begin
    if (rst || reg_defaults_restore) begin
      term_block_ff <= 1'b0;
    end else if (!term_enable && !term_status_ff) begin
      term_block_ff <= 1'b1;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || reg_defaults_restore || restart) begin
      term_status_ff <= 1'b0;
    end else if (term_hit) begin
      term_status_ff <= 1'b1;
    end
  end

  // battery switch opens on termination, closes for supplement
  always_ff @(posedge clk) begin
    if (rst) battery_switch_on_ff <= 1'b1;
    else battery_switch_on_ff <= !term_status_ff || supplement_req;
  end

  // ==========================================================
  // top-off timer
  logic [1:0] topoff_sel_ff;
  logic [26:0] pre_cnt_ff;
  logic half_tog_ff;
  logic [11:0] topoff_sec_ff;
  logic tick;
  logic step;
  logic expire;
  logic term_rise;
  logic clr_timer;
  logic [11:0] topoff_target;
  assign term_rise = term_hit && !term_status_ff;
  assign clr_timer = restart || term_rise || reg_defaults_restore;
  assign tick = (pre_cnt_ff == 27'(TICK_CYC - 1)) && !safety_pause;
  // half rate drops every other tick
  assign step = tick && (!(safety_half_rate || ext_half_rate) || half_tog_ff);
  assign topoff_target = 12'(topoff_sel_ff * TOPOFF_STEP_SEC);
  assign expire = topoff_run_ff && step && (topoff_sec_ff == topoff_target - 12'h001);

  // setting captured only at termination
  always_ff @(posedge clk) begin
    if (rst) topoff_sel_ff <= 2'h0;
    else if (term_rise) topoff_sel_ff <= topoff_setting;
  end

  always_ff @(posedge clk) begin
    if (rst || clr_timer) begin
      pre_cnt_ff <= 27'h0;
      half_tog_ff <= 1'b0;
      topoff_sec_ff <= 12'h000;
    end else if (topoff_run_ff && !safety_pause) begin
      // paused along with the safety timers
      pre_cnt_ff <= tick ? 27'h0 : pre_cnt_ff + 27'h1;
      half_tog_ff <= tick ? !half_tog_ff : half_tog_ff;
      topoff_sec_ff <= step ? topoff_sec_ff + 12'h001 : topoff_sec_ff;
    end
  end

  always_ff @(posedge clk) begin
    if (rst || restart || reg_defaults_restore) begin
      topoff_run_ff <= 1'b0;
    end else if (term_rise) begin
      topoff_run_ff <= (topoff_setting != 2'h0);
    end else if (expire) begin
      topoff_run_ff <= 1'b0;
    end
  end

  // ==========================================================
  // charge phase code and flag
  logic [1:0] nxt_phase;
  assign nxt_phase = (!charging_allow_bit || temp_suspend) ? PHASE_IDLE :
                     topoff_run_ff ? PHASE_TOPOFF :
                     term_status_ff ? PHASE_IDLE :
                     cv_regulation ? PHASE_CV : PHASE_CC;
  assign stat_blink = charging_allow_bit && temp_suspend;

  always_ff @(posedge clk) begin
    if (rst) begin
      charge_phase_code_ff <= PHASE_IDLE;
    end else begin
      charge_phase_code_ff <= nxt_phase;
    end
  end

  // entry and expiry both set the flag; set beats the read
  always_ff @(posedge clk) begin
    if (rst) charge_phase_flag_ff <= 1'b0;
    else if ((term_rise && topoff_setting != 2'h0) || expire) charge_phase_flag_ff <= 1'b1;
    else if (flag_read) charge_phase_flag_ff <= 1'b0;
  end

  // ==========================================================
  // checks
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  property p_term_cond;
    $rose(term_status_ff) |-> $past(vbat_above_recharge) && $past(cv_regulation) &&
                               $past(below_term_current);
  endproperty
  a_term_cond: assert property (p_term_cond) else $error("term without condition");

  property p_term_loops;
    $rose(term_status_ff) |-> !$past(input_current_limit_loop) && !$past(thermal_reg_loop) &&
                               !$past(input_voltage_limit_loop);
  endproperty
  a_term_loops: assert property (p_term_loops) else $error("term during loop");

  property p_switch;
    term_status_ff && !supplement_req |=> !battery_switch_on_ff;
  endproperty
  a_switch: assert property (p_switch) else $error("switch not opened");

  property p_block;
    term_block_ff && !reg_defaults_restore |=> term_block_ff && !$rose(term_status_ff);
  endproperty
  a_block: assert property (p_block) else $error("term while disabled");

  property p_qual;
    $rose(term_status_ff) |-> $past(term_cond, 8) && $past(term_cond, 2);
  endproperty
  a_qual: assert property (p_qual) else $error("term not qualified");

  property p_bypass_zone;
    thermistor_bypass [*2] |-> temp_zone_code_ff == ZONE_NOMINAL;
  endproperty
  a_bypass_zone: assert property (p_bypass_zone) else $error("bypass zone not 000");

  property p_conv_off;
    thermistor_bypass |=> thermistor_conversion_off_ff;
  endproperty
  a_conv_off: assert property (p_conv_off) else $error("conv off not held");

  property p_irq;
    zone_change && !temp_zone_irq_mask |=> !irq_n [*2];
  endproperty
  a_irq: assert property (p_irq) else $error("missing zone interrupt");

  property p_flag_set;
    zone_change |=> zone_flags_ff[$past(eff_zone)];
  endproperty
  a_flag_set: assert property (p_flag_set) else $error("zone flag not set");

  property p_pause;
    safety_pause && topoff_run_ff && !clr_timer |=> $stable(topoff_sec_ff);
  endproperty
  a_pause: assert property (p_pause) else $error("top-off ran while paused");

  property p_phase_susp;
    temp_suspend |=> charge_phase_code_ff == PHASE_IDLE;
  endproperty
  a_phase_susp: assert property (p_phase_susp) else $error("phase not 00 on suspend");

  c_term: cover property ($rose(term_status_ff));
  c_topoff_done: cover property (expire);
  c_zone_irq: cover property ($fell(irq_n));
  c_suspend: cover property (stat_blink);

endmodule // ctq_core

// ==== verif/ctq_host_model.sv ====
/*
  host side model: holds the configuration bits that the controller writes.
  assumes the bench calls its tasks in the time step of a rising clk edge.
*/
`timescale 1ns/1ps
module ctq_host_model (
  // clock
  input wire logic clk,
  // configuration toward the block
  output logic charging_allow_bit,
  output logic term_enable,
  output logic reg_defaults_restore,
  output logic [1:0] topoff_setting,
  output logic thermistor_bypass,
  output logic conv_off_wr,
  output logic conv_off_wdata,
  output logic temp_zone_irq_mask,
  output logic [1:0] foldback_precool_zone,
  output logic [1:0] foldback_cool_zone,
  output logic [1:0] foldback_prewarm_zone,
  output logic [1:0] foldback_warm_zone,
  output logic [1:0] battery_c_rate_select,
  output logic flag_read
);
  // ==========================================================
  // power-on values: charging allowed, full current in all four fold-back zones
  initial begin
    {charging_allow_bit, term_enable, topoff_setting} = 4'hd;
    {thermistor_bypass, temp_zone_irq_mask, battery_c_rate_select} = 4'h0;
    {foldback_warm_zone, foldback_prewarm_zone, foldback_cool_zone} = 6'h3f;
    foldback_precool_zone = 2'h3;
    {flag_read, reg_defaults_restore, conv_off_wr, conv_off_wdata} = 4'h0;
  end
  // ==========================================================
  // register writes, launched on the rising edge
  task automatic cfg(input logic al, input logic te, input logic by, input logic mk);
    charging_allow_bit <= al;
    term_enable <= te;
    thermistor_bypass <= by;
    temp_zone_irq_mask <= mk;
  endtask
  // c-rate follows the pack rating, else the fold-back is scaled wrongly
  task automatic fold(input logic [7:0] f, input logic [1:0] rate);
    {foldback_warm_zone, foldback_prewarm_zone, foldback_cool_zone} <= f[7:2];
    foldback_precool_zone <= f[1:0];
    battery_c_rate_select <= rate;
  endtask
  // one-cycle strobes: 0 flag read, 1 defaults restore, 2 conversion-off write
  task automatic strobe(input int which, input logic d);
    @(posedge clk);
    flag_read <= (which == 0);
    reg_defaults_restore <= (which == 1);
    conv_off_wr <= (which == 2);
    conv_off_wdata <= d;
    @(posedge clk);
    {flag_read, reg_defaults_restore, conv_off_wr} <= 3'h0;
  endtask
endmodule // ctq_host_model

// ==== verif/ctq_testbench.sv ====
/*
  self-checking bench for the charge termination and temperature qualifier.
  assumes short counts: four-cycle interrupt pulse and four-cycle timer tick.
*/
`timescale 1ns/1ps
`define CHK(o, e) begin checks++; if ((o) !== (e)) begin errors++; \
  $display("wrong value at %0t got %h expected %h", $time, o, e); end end
module testbench;
  import ctq_pkg::*;
  typedef struct {int sel; logic [9:0] exp;} ctq_note_t;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic vbat_above_recharge = 0, cv_regulation = 0, below_term_current = 0;
  logic input_current_limit_loop = 0, input_voltage_limit_loop = 0, thermal_reg_loop = 0;
  logic supplement_req = 0, ext_timer_pause = 0, ext_half_rate = 0;
  logic [2:0] zone_raw = 3'h0;
  logic charging_allow_bit, term_enable, reg_defaults_restore, conv_off_wr, conv_off_wdata;
  logic thermistor_bypass, temp_zone_irq_mask, flag_read;
  logic [1:0] topoff_setting, battery_c_rate_select;
  logic [1:0] foldback_precool_zone, foldback_cool_zone, foldback_prewarm_zone;
  logic [1:0] foldback_warm_zone, charge_phase_code_ff, fd;
  logic term_status_ff, battery_switch_on_ff, charge_phase_flag_ff, topoff_run_ff;
  logic thermistor_conversion_off_ff, irq_n, safety_half_rate, safety_pause, stat_blink;
  logic [2:0] temp_zone_code_ff;
  logic [6:0] zone_flags_ff, fl = 7'h00;
  logic [9:0] foldback_pct_ff;
  logic [31:0] seed = 32'h4b78;
  logic [2:0] zt [4] = '{ZONE_PRECOOL, ZONE_COOL, ZONE_PREWARM, ZONE_WARM};
  logic snap = 1'b0;
  int errors = 0, checks = 0, irq_cnt = 0, wait_cnt = 0;
  ctq_note_t notes[$];
  ctq_note_t cur;
  // ==========================================================
  // design and host model
  ctq_core #(.IRQ_CYC(4), .TICK_CYC(4)) uut (.clk, .rst, .vbat_above_recharge,
    .cv_regulation, .below_term_current, .input_current_limit_loop,
    .input_voltage_limit_loop, .thermal_reg_loop, .supplement_req, .ext_timer_pause,
    .ext_half_rate, .charging_allow_bit, .term_enable, .reg_defaults_restore,
    .topoff_setting, .zone_raw, .thermistor_bypass, .conv_off_wr, .conv_off_wdata,
    .temp_zone_irq_mask, .foldback_precool_zone, .foldback_cool_zone,
    .foldback_prewarm_zone, .foldback_warm_zone, .battery_c_rate_select, .flag_read,
    .term_status_ff, .battery_switch_on_ff, .charge_phase_code_ff, .charge_phase_flag_ff,
    .topoff_run_ff, .temp_zone_code_ff, .zone_flags_ff, .thermistor_conversion_off_ff,
    .irq_n, .foldback_pct_ff, .safety_half_rate, .safety_pause, .stat_blink);
  ctq_host_model host (.clk, .charging_allow_bit, .term_enable, .reg_defaults_restore,
    .topoff_setting, .thermistor_bypass, .conv_off_wr, .conv_off_wdata,
    .temp_zone_irq_mask, .foldback_precool_zone, .foldback_cool_zone,
    .foldback_prewarm_zone, .foldback_warm_zone, .battery_c_rate_select, .flag_read);
  // 125 MHz clock
  always #4 clk = ~clk;
  // interrupt pulses counted on their leading edge
  always @(negedge irq_n) if (!rst) irq_cnt++;
  // ==========================================================
  // helpers
  function automatic logic [31:0] xs(input logic [31:0] x);
    x ^= x << 13;
    x ^= x >> 17;
    x ^= x << 5;
    return x;
  endfunction
  function automatic logic [9:0] pct(input logic [1:0] f, input logic [1:0] r);
    case (f)
      FOLD_SUSPEND: return PCT_ZERO;
      FOLD_FULL: return PCT_FULL;
      FOLD_LOW: return r == 0 ? PCT_20 : r == 1 ? PCT_10 : r == 2 ? PCT_5 : PCT_3P3;
      default: return r == 0 ? PCT_40 : r == 1 ? PCT_20 : r == 2 ? PCT_10 : PCT_6P6;
    endcase
  endfunction
  function automatic logic [9:0] observe(input int s);
    case (s)
      0: return foldback_pct_ff;
      1: return {7'h00, temp_zone_code_ff};
      2: return {9'h000, term_status_ff};
      3: return {8'h00, charge_phase_code_ff};
      4: return {9'h000, charge_phase_flag_ff};
      5: return {9'h000, thermistor_conversion_off_ff};
      6: return {3'h0, zone_flags_ff};
      7: return irq_cnt[9:0];
      8: return {7'h00, safety_pause, stat_blink, safety_half_rate};
      9: return {9'h000, battery_switch_on_ff};
      default: return {9'h000, topoff_run_ff};
    endcase
  endfunction
  task automatic note(input int s, input logic [9:0] e);
    notes.push_back('{s, e});
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
  endtask
  // the monitor compares every pending note against the state of the last edge
  task automatic look();
    snap <= 1'b1;
    tick(1);
    snap <= 1'b0;
    tick(1);
  endtask
  task automatic term_try(input int n, input logic [2:0] loops);
    {input_current_limit_loop, input_voltage_limit_loop, thermal_reg_loop} <= loops;
    {cv_regulation, below_term_current} <= 2'h3;
    tick(n);
    {cv_regulation, below_term_current} <= 2'h0;
    {input_current_limit_loop, input_voltage_limit_loop, thermal_reg_loop} <= 3'h0;
    tick(2);
  endtask
  task automatic complete_run();
    $display("checks %0d errors %0d", checks, errors);
    if (errors == 0 && checks > 0) begin
      $display("All checks passed");
    end else begin
      $display("Checks failed");
    end
    $finish;
  endtask
  // monitor: oldest note first, on each snapshot
  always @(posedge clk) begin
    if (snap) begin
      while (notes.size() > 0) begin
        cur = notes.pop_front();
        `CHK(observe(cur.sel), cur.exp)
      end
    end
  end
  // ==========================================================
  // main sequence
  initial begin
    tick(4);
    rst <= 1'b0;
    tick(2);
    note(2, 0);
    note(0, PCT_FULL);
    note(1, 0);
    note(6, 0);
    note(5, 0);
    note(9, 1);
    look();
    $display("test reset done");
    vbat_above_recharge <= 1'b1;
    for (int i = 0; i < 3; i++) term_try(12, 3'h4 >> i);
    note(2, 0);
    look();
    term_try(7, 3'h0);
    note(2, 0);
    look();
    host.strobe(0, 1'b0);
    ext_half_rate <= 1'b1;
    term_try(8, 3'h0);
    note(2, 1);
    note(10, 1);
    note(3, PHASE_TOPOFF);
    note(4, 1);
    note(9, 0);
    look();
    supplement_req <= 1'b1;
    tick(3);
    note(9, 1);
    host.strobe(0, 1'b0);
    // a 40-cycle pause in the middle of a half-rate top-off
    ext_timer_pause <= 1'b1;
    tick(40);
    ext_timer_pause <= 1'b0;
    for (wait_cnt = 0; wait_cnt < 9000 && topoff_run_ff === 1'b1; wait_cnt++) tick(1);
    if (topoff_run_ff !== 1'b0) begin
      errors++;
      complete_run();
    end
    ext_half_rate <= 1'b0;
    // 900 steps of two four-cycle ticks, plus the pause, less the edges spent before the wait
    `CHK(wait_cnt, 8 * TOPOFF_STEP_SEC + 40 - 48)
    tick(2);
    note(4, 1);
    note(3, PHASE_IDLE);
    look();
    $display("test termination done");
    host.cfg(0, 1, 0, 0);
    tick(3);
    note(2, 0);
    note(10, 0);
    look();
    host.cfg(1, 0, 0, 0);
    term_try(10, 3'h0);
    note(2, 0);
    look();
    host.cfg(1, 1, 0, 0);
    host.strobe(1, 1'b0);
    term_try(8, 3'h0);
    note(2, 1);
    look();
    supplement_req <= 1'b0;
    host.cfg(0, 1, 0, 0);
    tick(2);
    host.cfg(1, 1, 0, 0);
    $display("test restart done");
    for (int z = 1; z < 8; z++) begin
      zone_raw <= 3'(z % 7);
      tick(8);
      fl[z % 7] = 1'b1;
      note(1, 10'(z % 7));
      note(6, fl);
      note(7, 10'(z));
      look();
    end
    host.strobe(0, 1'b0);
    host.cfg(1, 1, 0, 1);
    zone_raw <= ZONE_COOL;
    tick(8);
    note(6, 7'h04);
    note(7, 10'h007);
    look();
    zone_raw <= ZONE_COLD;
    tick(4);
    note(8, 10'h006);
    note(3, PHASE_IDLE);
    look();
    host.cfg(1, 1, 1, 1);
    tick(3);
    host.strobe(2, 1'b0);
    tick(2);
    note(1, ZONE_NOMINAL);
    note(8, 0);
    note(5, 1);
    look();
    host.cfg(1, 1, 0, 1);
    tick(2);
    host.strobe(2, 1'b0);
    tick(2);
    note(5, 0);
    look();
    $display("test zones done");
    for (int i = 0; i < 40; i++) begin
      seed = xs(seed);
      host.fold(i < 16 ? {4{i[3:2]}} : seed[7:0], i < 16 ? i[1:0] : seed[9:8]);
      zone_raw <= zt[seed[11:10]];
      tick(4);
      fd = i < 16 ? i[3:2] : seed[2 * seed[11:10] +: 2];
      note(0, pct(fd, i < 16 ? i[1:0] : seed[9:8]));
      note(8, {fd == 2'h0, fd == 2'h0, seed[10] && (fd == 2'h1 || fd == 2'h2)});
      look();
    end
    $display("test fold-back done");
    complete_run();
  end
endmodule // testbench
